// ---- udma_engine.sv ----
`default_nettype none

module udma_engine
(
    // Clock and reset
    input  wire logic                    SYS_CLK_IN,
    input  wire logic                    RSTN_IN,
    // Special function register port
    input  wire udma_pkg::udma_sfr_req_t SFR_IN,
    output logic [7:0]                   SFR_RDATA_OUT,
    // Control register port
    input  wire udma_pkg::udma_cr_req_t  CR_IN,
    // Interrupt sources and controller
    input  wire logic [63:0]             SRC_IRQ_IN,
    output logic [63:0]                  FLAG_OUT,
    output logic [7:0]                   END_IRQ_OUT,
    // CPU status and request
    input  wire logic [2:0]              CPU_MASK_IN,
    input  wire logic                    STANDBY_IN,
    output logic                         UDMA_REQ_OUT,
    output logic [2:0]                   UDMA_LEVEL_OUT,
    output logic                         BUS_HOLD_OUT,
    // Memory bus
    input  wire logic                    MEM_ACK_IN,
    input  wire logic [31:0]             MEM_RDATA_IN,
    output udma_pkg::udma_mem_req_t      MEM_OUT
);

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [2:0] first_ch(input logic [7:0] p);
        first_ch = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (p[i])
            begin
                first_ch = 3'(i);
            end
        end
    endfunction

    function automatic logic valid_vec(input logic [7:0] v);
        valid_vec = (v[7:6] == 2'h0) && (v[5:0] >= udma_pkg::VEC_FIRST)
                    && (v[5:0] <= udma_pkg::VEC_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    udma_pkg::udma_eng_t  s_r;
    udma_pkg::udma_eng_t  s_nxt;
    udma_pkg::udma_chan_t cur_ch;
    udma_pkg::udma_chan_t stp_ch;
    logic                 stp_zero;
    logic [7:0]           pend;
    logic [7:0]           armed;
    logic                 accept;
    logic [2:0]           pick;
    logic                 cnt_mode;
    logic [5:0]           acc_vec;
    logic [63:0]          flag_set;

    assign cur_ch = s_r.ch[s_r.cur];
    assign flag_set = SRC_IRQ_IN;

    ////////////////////////////////////////////////////////////////////////
    // Per channel trigger
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_pend
            assign armed[g] = s_r.dsel[g] && valid_vec(s_r.svec[g]); // R23
            assign pend[g] = (armed[g] && s_r.flag[s_r.svec[g][5:0]]) // R3
                             || s_r.swreq[g];                       // R15
        end
    endgenerate

    assign pick = first_ch(pend);                                   // R10
    assign accept = (s_r.st == udma_pkg::ST_IDLE) && (|pend)
                    && (CPU_MASK_IN != udma_pkg::MASK_BLOCK)        // R4
                    && !STANDBY_IN;                                 // R2
    assign cnt_mode = (s_r.ch[pick].mode == udma_pkg::MODE_COUNT);
    assign acc_vec = s_r.svec[pick][5:0];

    udma_step u_step
    (
        .chan_in  (cur_ch),
        .chan_out (stp_ch),
        .zero_out (stp_zero)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.endirq = 8'h00;
        s_nxt.req = |pend;
        s_nxt.lvl = udma_pkg::LEVEL_UDMA;                           // R1
        case (s_r.st)
            udma_pkg::ST_IDLE:
            begin
                if (accept)
                begin
                    s_nxt.cur = pick;
                    s_nxt.hold = 1'b1;
                    if (armed[pick])
                    begin
                        s_nxt.flag[acc_vec] = 1'b0;                 // R5
                    end
                    if (cnt_mode)
                    begin
                        s_nxt.st = udma_pkg::ST_UPD;                // R21
                    end
                    else
                    begin
                        s_nxt.st = udma_pkg::ST_RD;                 // R6
                        s_nxt.mem.rd = 1'b1;
                        s_nxt.mem.addr = s_r.ch[pick].src[23:0];    // R12
                        s_nxt.mem.size = s_r.ch[pick].mode[1:0];    // R22
                    end
                end
            end
            udma_pkg::ST_RD:
            begin
                if (MEM_ACK_IN)
                begin
                    s_nxt.st = udma_pkg::ST_WR;                     // R6
                    s_nxt.mem.rd = 1'b0;
                    s_nxt.mem.wr = 1'b1;
                    s_nxt.mem.addr = cur_ch.dst[23:0];              // R12
                    s_nxt.mem.wdata = MEM_RDATA_IN;
                end
            end
            udma_pkg::ST_WR:
            begin
                if (MEM_ACK_IN)
                begin
                    s_nxt.st = udma_pkg::ST_UPD;
                    s_nxt.mem.wr = 1'b0;
                end
            end
            udma_pkg::ST_UPD:
            begin
                s_nxt.ch[s_r.cur] = stp_ch;                         // R6
                s_nxt.swreq[s_r.cur] = 1'b0;                        // R16
                if (stp_zero)
                begin
                    s_nxt.endirq[s_r.cur] = 1'b1;                   // R7
                    s_nxt.svec[s_r.cur] = 8'h00;                    // R8
                end
                if (s_r.burst[s_r.cur] && !stp_zero)
                begin
                    if (cur_ch.mode == udma_pkg::MODE_COUNT)
                    begin
                        s_nxt.st = udma_pkg::ST_UPD;                // R17
                    end
                    else
                    begin
                        s_nxt.st = udma_pkg::ST_RD;                 // R17
                        s_nxt.mem.rd = 1'b1;
                        s_nxt.mem.addr = stp_ch.src[23:0];          // R12
                        s_nxt.mem.size = stp_ch.mode[1:0];
                    end
                end
                else
                begin
                    s_nxt.st = udma_pkg::ST_IDLE;                   // R25
                    s_nxt.hold = 1'b0;                              // R25
                end
            end
            default:
            begin
                s_nxt.st = udma_pkg::ST_IDLE;
                s_nxt.hold = 1'b0;
                s_nxt.mem = '0;
            end
        endcase

        // Register writes take precedence over engine clears
        if (SFR_IN.wr)
        begin
            if (SFR_IN.addr[11:3] == udma_pkg::ADR_SVEC0[11:3])
            begin
                s_nxt.svec[SFR_IN.addr[2:0]] = SFR_IN.wdata;        // R23
            end
            case (SFR_IN.addr)
                udma_pkg::ADR_SWREQ:
                    s_nxt.swreq = s_nxt.swreq | SFR_IN.wdata;       // R15
                udma_pkg::ADR_BURST:
                    s_nxt.burst = SFR_IN.wdata;
                udma_pkg::ADR_DSEL:
                    s_nxt.dsel = SFR_IN.wdata;
                udma_pkg::ADR_REQUEST_FLAG_CLEAR_REG:
                    s_nxt.flag[SFR_IN.wdata[5:0]] = 1'b0;           // R24
                default:
                    s_nxt.dsel = s_nxt.dsel;
            endcase
        end
        if (CR_IN.wr)
        begin
            case (CR_IN.kind)
                udma_pkg::CR_SRC:
                    s_nxt.ch[CR_IN.ch].src = CR_IN.data;            // R12
                udma_pkg::CR_DST:
                    s_nxt.ch[CR_IN.ch].dst = CR_IN.data;            // R12
                udma_pkg::CR_CNT:
                    s_nxt.ch[CR_IN.ch].cnt = CR_IN.data[15:0];      // R13
                default:
                    s_nxt.ch[CR_IN.ch].mode = CR_IN.data[4:0];
            endcase
        end

        // Source events win over any clear
        for (int i = 0; i < 64; i++)
        begin
            if (flag_set[i] && valid_vec(8'(i)))                    // R14
            begin
                s_nxt.flag[i] = 1'b1;
            end
        end

        s_nxt.rdata = 8'h00;
        if (SFR_IN.rd)
        begin
            if (SFR_IN.addr[11:3] == udma_pkg::ADR_SVEC0[11:3])
            begin
                s_nxt.rdata = s_r.svec[SFR_IN.addr[2:0]];
            end
            else if (SFR_IN.addr == udma_pkg::ADR_SWREQ)
            begin
                s_nxt.rdata = s_r.swreq;                            // R16
            end
            else if (SFR_IN.addr == udma_pkg::ADR_BURST)
            begin
                s_nxt.rdata = s_r.burst;
            end
            else if (SFR_IN.addr == udma_pkg::ADR_DSEL)
            begin
                s_nxt.rdata = s_r.dsel;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RSTN_IN)
        begin
            s_r <= udma_pkg::ENG_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign SFR_RDATA_OUT  = s_r.rdata;
    assign FLAG_OUT       = s_r.flag;
    assign END_IRQ_OUT    = s_r.endirq;
    assign UDMA_REQ_OUT   = s_r.req;
    assign UDMA_LEVEL_OUT = s_r.lvl;
    assign BUS_HOLD_OUT   = s_r.hold;
    assign MEM_OUT        = s_r.mem;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    sequence s_rd_done;
        (s_r.st == udma_pkg::ST_RD) && MEM_ACK_IN;
    endsequence

    sequence s_wr_issue;
        (s_r.st == udma_pkg::ST_WR) && MEM_OUT.wr && !MEM_OUT.rd;
    endsequence

    AST_LEVEL: assert property (UDMA_REQ_OUT |-> UDMA_LEVEL_OUT == 3'h6) // R1
        else $error("request not at level six");

    AST_STANDBY: assert property (                                  // R2
        (s_r.st == udma_pkg::ST_IDLE) && STANDBY_IN
        |=> (s_r.st == udma_pkg::ST_IDLE) && !BUS_HOLD_OUT)
        else $error("service started in standby");

    AST_MASK: assert property (                                     // R4
        (s_r.st == udma_pkg::ST_IDLE) && (CPU_MASK_IN == 3'h7)
        |=> (s_r.st == udma_pkg::ST_IDLE))
        else $error("request accepted at mask seven");

    AST_NOTRIG: assert property (                                   // R3
        (s_r.st == udma_pkg::ST_IDLE) && (pend == 8'h00)
        |=> !BUS_HOLD_OUT)
        else $error("transfer without trigger");

    AST_FLAGCLR: assert property (                                  // R5
        accept && armed[pick] && !SRC_IRQ_IN[acc_vec]
        |=> !FLAG_OUT[$past(acc_vec)])
        else $error("request flag not cleared on accept");

    AST_PRIO: assert property (                                     // R10
        accept |=> ($past(pend) & ((8'h01 << s_r.cur) - 8'h01)) == 8'h00)
        else $error("lower channel skipped");

    AST_RDWR: assert property (s_rd_done |=> s_wr_issue)            // R6
        else $error("write did not follow read");

    AST_CNT: assert property (                                      // R6
        (s_r.st == udma_pkg::ST_UPD) && !CR_IN.wr
        |=> s_r.ch[$past(s_r.cur)].cnt == $past(cur_ch.cnt) - 16'h1)
        else $error("counter not decremented");

    AST_END: assert property (                                      // R7
        (s_r.st == udma_pkg::ST_UPD) && stp_zero && !SFR_IN.wr
        |=> END_IRQ_OUT[$past(s_r.cur)] && s_r.svec[$past(s_r.cur)] == 8'h00
        ##1 END_IRQ_OUT == 8'h00)
        else $error("end of count mishandled");

    AST_SWCLR: assert property (                                    // R16
        (s_r.st == udma_pkg::ST_UPD) && !SFR_IN.wr
        |=> !s_r.swreq[$past(s_r.cur)])
        else $error("software request not cleared");

    AST_SINGLE: assert property (                                   // R25
        (s_r.st == udma_pkg::ST_UPD) && !s_r.burst[s_r.cur]
        |=> (s_r.st == udma_pkg::ST_IDLE) && !BUS_HOLD_OUT)
        else $error("bus kept after single transfer");

    AST_BURST: assert property (                                    // R17
        (s_r.st == udma_pkg::ST_UPD) && s_r.burst[s_r.cur] && !stp_zero
        |=> BUS_HOLD_OUT && (s_r.st != udma_pkg::ST_IDLE))
        else $error("burst broke before zero");

endmodule

`default_nettype wire

// ---- udma_pkg.sv ----
// Operation
// R1 - Every armed request goes to the CPU at level 6, whatever source priority.
// R2 - No service while the CPU is in standby; requests wait.
// R3 - Request only from the source named by the start vector, micro DMA selected.
// R4 - Refuse all requests while the CPU mask level equals 7.
// R5 - Accepting a request clears the triggering source's request flag.
// R6 - Each accept moves one unit source to destination, counter minus one.
// R7 - Nonzero counter leaves channel armed; zero raises the channel end interrupt.
// R8 - Counter reaching zero also clears the channel's start vector.
// R9 - Software sets trigger-only source priority to zero first.
// R10 - Simultaneous requests served by channel number, channel 0 first.
// R11 - Software never arms two channels with one source.
// R12 - Address registers hold 32 bits; only the low 24 drive the bus.
// R13 - Counter is 16 bits; zero start gives 65536 transfers.
// R14 - 47 vector sources plus a software start can trigger transfers; the engine accepts 50, vectors 0x0A to 0x3B.
// R15 - Writing one to a software request bit triggers one transfer.
// R16 - Completed software transfer clears its request bit; software may set again.
// R17 - Burst channel runs back-to-back transfers until its counter is zero.
// R18 - Software sets one software request at a time, after all complete.
// R19 - Modes 100 and 101 step both addresses up or down, six states.
// R20 - Modes 000 to 011 step one address; 110 fixed; five states.
// R21 - Mode 11100 counts: no data, source plus one, counter minus one.
// R22 - Low two mode bits give size 1, 2 or 4 bytes; 11 reserved.
// R23 - Writing a source's vector into a start vector register arms the channel.
// R24 - Writing a vector to the flag clear register clears that flag.
// R25 - Outside burst, control returns to the CPU after each transfer.
`default_nettype none

package udma_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [11:0] ADR_SVEC0  = 12'h100;
    localparam logic [11:0] ADR_SWREQ  = 12'h109;
    localparam logic [11:0] ADR_BURST  = 12'h10A;
    localparam logic [11:0] ADR_DSEL   = 12'h10B;
    localparam logic [11:0] ADR_REQUEST_FLAG_CLEAR_REG = 12'h10C;

    // Control register kinds
    localparam logic [1:0] CR_SRC  = 2'h0;
    localparam logic [1:0] CR_DST  = 2'h1;
    localparam logic [1:0] CR_CNT  = 2'h2;
    localparam logic [1:0] CR_MODE = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Levels, vectors, modes
    localparam logic [2:0] LEVEL_UDMA = 3'h6;
    localparam logic [2:0] MASK_BLOCK = 3'h7;
    localparam logic [5:0] VEC_FIRST  = 6'h0A;
    localparam logic [5:0] VEC_LAST   = 6'h3B;
    localparam logic [4:0] MODE_COUNT = 5'h1C;
    localparam logic [2:0] OP_DINC    = 3'h0;
    localparam logic [2:0] OP_DDEC    = 3'h1;
    localparam logic [2:0] OP_SINC    = 3'h2;
    localparam logic [2:0] OP_SDEC    = 3'h3;
    localparam logic [2:0] OP_BINC    = 3'h4;
    localparam logic [2:0] OP_BDEC    = 3'h5;
    localparam logic [1:0] SZ_BYTE    = 2'h0;
    localparam logic [1:0] SZ_WORD    = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_RD   = 2'h1,
        ST_WR   = 2'h3,
        ST_UPD  = 2'h2
    } udma_state_t;

    typedef struct packed
    {
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] cnt;
        logic [4:0]  mode;
    } udma_chan_t;

    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } udma_sfr_req_t;

    typedef struct packed
    {
        logic        wr;
        logic [2:0]  ch;
        logic [1:0]  kind;
        logic [31:0] data;
    } udma_cr_req_t;

    typedef struct packed
    {
        logic        rd;
        logic        wr;
        logic [23:0] addr;
        logic [1:0]  size;
        logic [31:0] wdata;
    } udma_mem_req_t;

    typedef struct packed
    {
        udma_state_t          st;
        logic [2:0]           cur;
        logic [7:0][7:0]      svec;
        logic [7:0]           dsel;
        logic [7:0]           burst;
        logic [7:0]           swreq;
        logic [63:0]          flag;
        udma_chan_t [7:0]     ch;
        udma_mem_req_t        mem;
        logic [7:0]           rdata;
        logic [7:0]           endirq;
        logic                 hold;
        logic                 req;
        logic [2:0]           lvl;
    } udma_eng_t;

    // All registers clear at reset
    localparam udma_eng_t ENG_RST = '0;

endpackage

`default_nettype wire

// ---- udma_step.sv ----
`default_nettype none

module udma_step
(
    // Channel before the transfer
    input  wire udma_pkg::udma_chan_t chan_in,
    // Channel after the transfer
    output udma_pkg::udma_chan_t      chan_out,
    output logic                      zero_out
);

    logic [31:0] step;

    always_comb
    begin
        case (chan_in.mode[1:0])                                    // R22
            udma_pkg::SZ_BYTE: step = 32'h1;
            udma_pkg::SZ_WORD: step = 32'h2;
            default:           step = 32'h4;
        endcase
        chan_out = chan_in;
        chan_out.cnt = chan_in.cnt - 16'h1;                         // R13
        if (chan_in.mode == udma_pkg::MODE_COUNT)
        begin
            chan_out.src = chan_in.src + 32'h1;                     // R21
        end
        else
        begin
            case (chan_in.mode[4:2])
                udma_pkg::OP_DINC: chan_out.dst = chan_in.dst + step; // R20
                udma_pkg::OP_DDEC: chan_out.dst = chan_in.dst - step; // R20
                udma_pkg::OP_SINC: chan_out.src = chan_in.src + step; // R20
                udma_pkg::OP_SDEC: chan_out.src = chan_in.src - step; // R20
                udma_pkg::OP_BINC:
                begin
                    chan_out.src = chan_in.src + step;              // R19
                    chan_out.dst = chan_in.dst + step;              // R19
                end
                udma_pkg::OP_BDEC:
                begin
                    chan_out.src = chan_in.src - step;              // R19
                    chan_out.dst = chan_in.dst - step;              // R19
                end
                default:
                begin
                    chan_out.src = chan_in.src;                     // R20
                end
            endcase
        end
        zero_out = (chan_out.cnt == 16'h0);                         // R7
    end

endmodule

`default_nettype wire

// ---- udma_mem_model.sv ----
`default_nettype none

module udma_mem_model
(
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    rstn_in,
    // Request and answer delay
    input  wire udma_pkg::udma_mem_req_t mem_in,
    input  wire logic [1:0]              lat_in,
    // Answer
    output logic                         ack_out,
    output logic [31:0]                  rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] wait_r;

    ////////////////////////////////////////////////////////////////////////
    // One ack per request after lat_in cycles; data churns when not valid
    always_ff @(posedge clk_in)
    begin
        ack_out   <= 1'b0;
        rdata_out <= ~rdata_out;
        if (!rstn_in)
        begin
            wait_r    <= 2'h0;
            rdata_out <= 32'h0;
        end
        else if ((mem_in.rd || mem_in.wr) && !ack_out)
        begin
            if (wait_r == lat_in)
            begin
                ack_out   <= 1'b1;
                wait_r    <= 2'h0;
                rdata_out <= {8'h5A, mem_in.addr};
            end
            else
                wait_r <= wait_r + 2'h1;
        end
    end

endmodule

`default_nettype wire

// ---- test_udma_engine.sv ----
`default_nettype none

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    failures++; $display("unexpected %s: expected %0h seen %0h", \
    nm, ex, got); end end

module test_udma_engine;
    timeunit 1ns;
    timeprecision 1ns;

    logic                    clk   = 1'b0;
    logic                    rstn  = 1'b0;
    udma_pkg::udma_sfr_req_t sfr   = '0;
    udma_pkg::udma_cr_req_t  cr    = '0;
    logic [63:0]             irq_v = 64'h0;
    logic [2:0]              mask  = 3'h0;
    logic                    stby  = 1'b0;
    logic [1:0]              lat   = 2'h0;
    logic                    ack;
    logic [31:0]             rdata;
    logic [7:0]              sfr_rd;
    logic [63:0]             flag;
    logic [7:0]              end_irq;
    logic [7:0]              end_seen = 8'h00;
    logic                    req;
    logic [2:0]              lvl;
    logic                    hold;
    udma_pkg::udma_mem_req_t mem;
    int                      failures   = 0;
    int                      n_compared = 0;
    int                      cyc        = 0;

    always #50 clk = ~clk;

    udma_engine dut
    (
        .SYS_CLK_IN     (clk),
        .RSTN_IN        (rstn),
        .SFR_IN         (sfr),
        .SFR_RDATA_OUT  (sfr_rd),
        .CR_IN          (cr),
        .SRC_IRQ_IN     (irq_v),
        .FLAG_OUT       (flag),
        .END_IRQ_OUT    (end_irq),
        .CPU_MASK_IN    (mask),
        .STANDBY_IN     (stby),
        .UDMA_REQ_OUT   (req),
        .UDMA_LEVEL_OUT (lvl),
        .BUS_HOLD_OUT   (hold),
        .MEM_ACK_IN     (ack),
        .MEM_RDATA_IN   (rdata),
        .MEM_OUT        (mem)
    );

    udma_mem_model mem_model
    (
        .clk_in    (clk),
        .rstn_in   (rstn),
        .mem_in    (mem),
        .lat_in    (lat),
        .ack_out   (ack),
        .rdata_out (rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Closing report and hang limit
    task summarize();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        end_seen <= end_seen | end_irq;
        cyc++;
        if (cyc == 4000)
        begin
            failures++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access tasks
    task tick();
        @(posedge clk);
        #1;
    endtask

    task sfr_wr(logic [11:0] a, logic [7:0] d);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick();
        sfr = '0;
        tick();
    endtask

    task sfr_chk(logic [11:0] a, logic [7:0] ex);
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick();
        sfr = '0;
        `CHK("register read", ex, sfr_rd)
        tick();
    endtask

    task cr_wr(logic [2:0] c, logic [1:0] k, logic [31:0] d);
        cr = '{wr: 1'b1, ch: c, kind: k, data: d};
        tick();
        cr = '0;
        tick();
    endtask

    task chan(logic [2:0] c, logic [31:0] s, logic [31:0] d,
              logic [15:0] n, logic [4:0] m);
        cr_wr(c, udma_pkg::CR_SRC, s);
        cr_wr(c, udma_pkg::CR_DST, d);
        cr_wr(c, udma_pkg::CR_CNT, {16'h0, n});
        cr_wr(c, udma_pkg::CR_MODE, {27'h0, m});
    endtask

    task fire(logic [63:0] m);
        irq_v = m;
        tick();
        irq_v = 64'h0;
        tick();
    endtask

    task xfer(logic [23:0] s, logic [23:0] d, logic [1:0] sz);
        int i;
        i = 0;
        while (mem.rd !== 1'b1 && i < 40)
        begin
            tick();
            i++;
        end
        `CHK("read address", {1'b1, s, sz}, {mem.rd, mem.addr, mem.size})
        i = 0;
        while (mem.wr !== 1'b1 && i < 40)
        begin
            tick();
            i++;
        end
        `CHK("write address", {1'b1, d}, {mem.wr, mem.addr})
        `CHK("write data", {8'h5A, s}, mem.wdata)
    endtask

    task quiet(int n);
        repeat (n)
        begin
            tick();
            `CHK("bus idle", 2'h0, {mem.rd, mem.wr})
        end
    endtask

    task gap();
        int i;
        i = 0;
        while (hold !== 1'b0 && i < 10)
        begin
            tick();
            i++;
        end
        `CHK("bus hold", 1'b0, hold)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [23:0] k;
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        tick();
        tick();
        `CHK("level", udma_pkg::LEVEL_UDMA, lvl)
        sfr_chk(udma_pkg::ADR_SWREQ, 8'h00);
        sfr_chk(12'h1FF, 8'h00);
        sfr_wr(udma_pkg::ADR_DSEL, 8'hFF);
        // Interrupt-started channel, two units
        chan(3'h0, 32'hAB001000, 32'h2000, 16'h2, 5'h01);
        sfr_wr(udma_pkg::ADR_SVEC0, 8'h0A);
        fire(64'h1 << 10);
        xfer(24'h001000, 24'h002000, udma_pkg::SZ_WORD);
        tick();
        `CHK("flag", 1'b0, flag[10])
        `CHK("end irq", 8'h00, end_seen)
        fire(64'h1 << 10);
        xfer(24'h001000, 24'h002002, udma_pkg::SZ_WORD);
        repeat (6) tick();
        `CHK("end irq", 8'h01, end_seen)
        sfr_chk(udma_pkg::ADR_SVEC0, 8'h00);
        fire(64'h1 << 10);
        quiet(8);
        `CHK("flag", 1'b1, flag[10])
        sfr_wr(udma_pkg::ADR_REQUEST_FLAG_CLEAR_REG, 8'h0A);
        `CHK("flag", 1'b0, flag[10])
        fire((64'h1 << 9) | (64'h1 << 59));
        `CHK("flags", 2'h1, {flag[9], flag[59]})
        sfr_wr(udma_pkg::ADR_REQUEST_FLAG_CLEAR_REG, 8'h3B);
        // Software start against mask 7 and standby
        chan(3'h1, 32'h3000, 32'h4000, 16'h2, 5'h1A);
        mask = 3'h7;
        sfr_wr(udma_pkg::ADR_SWREQ, 8'h02);
        quiet(8);
        `CHK("request", 1'b1, req)
        mask = 3'h6;
        stby = 1'b1;
        quiet(8);
        stby = 1'b0;
        xfer(24'h3000, 24'h4000, 2'h2);
        repeat (6) tick();
        sfr_chk(udma_pkg::ADR_SWREQ, 8'h00);
        `CHK("end irq", 8'h01, end_seen)
        sfr_wr(udma_pkg::ADR_SWREQ, 8'h02);
        xfer(24'h3000, 24'h4000, 2'h2);
        repeat (6) tick();
        `CHK("end irq", 8'h03, end_seen)
        // Two channels at once, distinct sources
        chan(3'h2, 32'h5000, 32'h5100, 16'h2, 5'h04);
        chan(3'h3, 32'h6000, 32'h6100, 16'h2, 5'h0D);
        sfr_wr(udma_pkg::ADR_SVEC0 + 12'h2, 8'h0B);
        sfr_wr(udma_pkg::ADR_SVEC0 + 12'h3, 8'h0C);
        fire(64'h3 << 11);
        xfer(24'h5000, 24'h5100, udma_pkg::SZ_BYTE);
        gap();
        xfer(24'h6000, 24'h6100, udma_pkg::SZ_WORD);
        fire(64'h3 << 11);
        xfer(24'h5000, 24'h50FF, udma_pkg::SZ_BYTE);
        gap();
        xfer(24'h5FFE, 24'h6100, udma_pkg::SZ_WORD);
        // Burst with slow memory
        lat = 2'h2;
        chan(3'h4, 32'h7000, 32'h8000, 16'h3, 5'h10);
        sfr_wr(udma_pkg::ADR_BURST, 8'h10);
        sfr_wr(udma_pkg::ADR_SVEC0 + 12'h4, 8'h0D);
        fire(64'h1 << 13);
        for (k = 24'h0; k < 24'h3; k++)
            xfer(24'h7000 + k, 24'h8000 + k, udma_pkg::SZ_BYTE);
        repeat (10) tick();
        `CHK("end irq", 8'h1F, end_seen)
        lat = 2'h0;
        // Counter mode, then source steps show the count
        sfr_wr(udma_pkg::ADR_BURST, 8'h00);
        chan(3'h5, 32'h9000, 32'hA000, 16'h1, udma_pkg::MODE_COUNT);
        sfr_wr(udma_pkg::ADR_SVEC0 + 12'h5, 8'h0E);
        fire(64'h1 << 14);
        quiet(10);
        `CHK("end irq", 8'h3F, end_seen)
        cr_wr(3'h5, udma_pkg::CR_MODE, 32'h08);
        cr_wr(3'h5, udma_pkg::CR_CNT, 32'h3);
        sfr_wr(udma_pkg::ADR_SVEC0 + 12'h5, 8'h0E);
        fire(64'h1 << 14);
        xfer(24'h9001, 24'hA000, udma_pkg::SZ_BYTE);
        gap();
        cr_wr(3'h5, udma_pkg::CR_MODE, 32'h16);
        fire(64'h1 << 14);
        xfer(24'h9002, 24'hA000, 2'h2);
        fire(64'h1 << 14);
        xfer(24'h8FFE, 24'h9FFC, 2'h2);
        repeat (8) tick();
        summarize();
    end

endmodule

`default_nettype wire
